// ---- inc/isi_pkg.sv ----
// constants and types shared by the two-wire status and event block
package isi_pkg;

  // ===========================================================
  // special-function register map
  localparam logic [7:0] ISI_ADDR_STATUS = 8'hDD;
  localparam logic [7:0] ISI_ADDR_DATA   = 8'hDE;
  localparam logic [7:0] ISI_ADDR_OWN    = 8'hDF;

  localparam logic [7:0] ISI_STATUS_RST  = 8'h00;
  localparam logic [7:0] ISI_DATA_RST    = 8'h00;
  localparam logic [7:0] ISI_OWN_RST     = 8'h00;
  localparam logic [7:0] ISI_UNMAPPED_RD = 8'h00;

  // ===========================================================
  // status field positions
  localparam int ISI_GC_BIT   = 7;
  localparam int ISI_STOP_BIT = 6;
  localparam int ISI_PEND_BIT = 5;
  localparam int ISI_TX_BIT   = 4;
  localparam int ISI_BUSY_BIT = 3;
  localparam int ISI_LOST_BIT = 2;
  localparam int ISI_NACK_BIT = 1;
  localparam int ISI_SLV_BIT  = 0;

  // ===========================================================
  // byte framing
  localparam logic [6:0] ISI_GC_ADDR   = 7'h00;
  localparam logic [3:0] ISI_LAST_DATA = 4'h7;
  localparam logic [3:0] ISI_ACK_SLOT  = 4'h8;
  localparam logic [3:0] ISI_ACK_DONE  = 4'h9;

  // ===========================================================
  // master bit timing: one bit is four quarter periods
  localparam int ISI_CLK_MHZ     = 100;
  localparam int ISI_QUARTER_NS  = 300;
  localparam int ISI_QUARTER_CYC =
    (ISI_QUARTER_NS * ISI_CLK_MHZ + 999) / 1000;

  typedef enum logic [2:0] {
    ISI_ST_IDLE  = 3'b000,
    ISI_ST_START = 3'b001,
    ISI_ST_XFER  = 3'b010,
    ISI_ST_HOLD  = 3'b011,
    ISI_ST_STOP  = 3'b100
  } isi_state_t;

endpackage

// ---- logic/isi_bus_sync.sv ----
// two-flop synchroniser and start, stop and clock-edge detection
`timescale 1ns/1ps
`default_nettype none
module isi_bus_sync (
  input  wire logic i_ref_clk,
  input  wire logic i_rst_n,
  input  wire logic i_scl,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda,
  output logic      o_scl_rise,
  output logic      o_scl_fall,
  output logic      o_start_det,
  output logic      o_stop_det
);
  // [0] is the metastable stage and feeds only [1]
  logic [1:0] scl_ff_q;
  logic [1:0] sda_ff_q;
  logic       scl_prev_q;
  logic       sda_prev_q;

  // idle bus level is high, so reset to high to avoid false edges
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      scl_ff_q   <= 2'h3;
      sda_ff_q   <= 2'h3;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_ff_q   <= {scl_ff_q[0], i_scl};
      sda_ff_q   <= {sda_ff_q[0], i_sda};
      scl_prev_q <= scl_ff_q[1];
      sda_prev_q <= sda_ff_q[1];
    end
  end

  assign o_scl       = scl_ff_q[1];
  assign o_sda       = sda_ff_q[1];
  assign o_scl_rise  = scl_ff_q[1] & ~scl_prev_q;
  assign o_scl_fall  = ~scl_ff_q[1] & scl_prev_q;
  assign o_start_det = scl_ff_q[1] & scl_prev_q
                     & ~sda_ff_q[1] & sda_prev_q;
  assign o_stop_det  = scl_ff_q[1] & scl_prev_q
                     & sda_ff_q[1] & ~sda_prev_q;
endmodule
`default_nettype wire

// ---- logic/isi_status_event.sv ----
// two-wire engine with status register and pending-event flag
`timescale 1ns/1ps
`default_nettype none
module isi_status_event
  import isi_pkg::*;
#(
  parameter int QUARTER_CYC = ISI_QUARTER_CYC,
  parameter int DIV_W       = $clog2(QUARTER_CYC + 1)
) (
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst_n,
  input  wire logic [7:0] i_sfr_addr,
  input  wire logic       i_sfr_wr,
  input  wire logic       i_sfr_rd,
  input  wire logic [7:0] i_sfr_wdata,
  output logic      [7:0] o_sfr_rdata,
  input  wire logic       i_engine_en,
  input  wire logic       i_auto_ack_enable,
  input  wire logic       i_start_req,
  input  wire logic       i_end_transfer_request,
  input  wire logic       i_bus_irq_enable,
  input  wire logic       i_global_irq_master,
  output logic            o_irq_req,
  output logic            o_start_done,
  output logic            o_stop_done,
  input  wire logic       i_scl,
  output logic            o_scl_o,
  output logic            o_scl_oe,
  input  wire logic       i_sda,
  output logic            o_sda_o,
  output logic            o_sda_oe
);

  // ===========================================================
  // bus sampling
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  isi_bus_sync u_sync (
    .i_ref_clk   (i_ref_clk),
    .i_rst_n     (i_rst_n),
    .i_scl       (i_scl),
    .i_sda       (i_sda),
    .o_scl       (scl),
    .o_sda       (sda),
    .o_scl_rise  (scl_rise),
    .o_scl_fall  (scl_fall),
    .o_start_det (start_det),
    .o_stop_det  (stop_det)
  );

  // ===========================================================
  // state
  isi_state_t       state_q;
  logic [DIV_W-1:0] div_q;
  logic [1:0]       phase_q;
  logic [3:0]       bit_cnt_q;
  logic [7:0]       shreg_q;
  logic [7:0]       data_q;
  logic [7:0]       own_q;
  logic [7:0]       rdata_q;
  logic             sda_low_q;
  logic             scl_low_q;
  logic             own_master_q;
  logic             addr_phase_q;
  logic             addressed_q;
  logic             lost_inflight_q;
  logic             go_hold_q;
  logic             rel_req_q;
  logic             start_pulse_q;
  logic             stop_pulse_q;
  logic             tx_q;
  logic             slave_q;
  logic             gc_q;
  logic             stop_q;
  logic             pend_q;
  logic             busy_q;
  logic             lost_q;
  logic             nack_q;

  // ===========================================================
  // timing points and byte-end decisions
  logic tick;
  logic drive_pt;
  logic sample_pt;
  logic ack_pt;
  logic addr_match;
  logic gen_call;
  logic slv_addr;
  logic take_addr;
  logic ev_pend;
  logic ev_gc;
  logic ev_lost;
  logic go_hold;
  logic data_wr;
  logic data_rd;
  logic stat_wr;
  logic rx_capture;
  logic [7:0] status;

  always_comb begin
    tick      = (div_q == '0) && (state_q != ISI_ST_IDLE);
    drive_pt  = own_master_q ? (tick && phase_q == 2'h0) : scl_fall;
    sample_pt = own_master_q ? (tick && phase_q == 2'h2 && scl)
                             : scl_rise;
    ack_pt    = (state_q == ISI_ST_XFER) && sample_pt
              && (bit_cnt_q == ISI_ACK_SLOT);
    addr_match = shreg_q[7:1] == own_q[7:1];
    gen_call   = shreg_q[7:1] == ISI_GC_ADDR;
    slv_addr   = addr_phase_q && !own_master_q;
    take_addr  = slv_addr && i_auto_ack_enable
               && (addr_match || gen_call);
    ev_pend = (ack_pt && (take_addr || own_master_q
                          || lost_inflight_q || addressed_q))
            || (stop_det && addressed_q && !own_master_q);
    ev_gc   = ack_pt && slv_addr && gen_call;
    ev_lost = (state_q == ISI_ST_XFER) && own_master_q && tx_q
            && sample_pt && (bit_cnt_q < ISI_ACK_SLOT)
            && !sda_low_q && !sda;
    if (own_master_q) begin
      go_hold = 1'b1;
    end else if (slv_addr) begin
      go_hold = take_addr;
    end else begin
      go_hold = addressed_q && !(tx_q && sda);
    end
    data_wr = i_sfr_wr && (i_sfr_addr == ISI_ADDR_DATA);
    data_rd = i_sfr_rd && (i_sfr_addr == ISI_ADDR_DATA);
    stat_wr = i_sfr_wr && (i_sfr_addr == ISI_ADDR_STATUS);
    rx_capture = (state_q == ISI_ST_XFER) && sample_pt && !tx_q
               && (bit_cnt_q == ISI_LAST_DATA);
  end

  // ===========================================================
  // quarter-bit divider for the master's own clock
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      div_q <= '0;
    end else if (state_q == ISI_ST_IDLE || div_q == '0) begin
      div_q <= DIV_W'(QUARTER_CYC - 1);
    end else begin
      div_q <= div_q - 1'b1;
    end
  end

  // ===========================================================
  // transfer sequencer
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n || !i_engine_en) begin
      state_q         <= ISI_ST_IDLE;
      phase_q         <= 2'h0;
      bit_cnt_q       <= 4'h0;
      shreg_q         <= 8'h00;
      sda_low_q       <= 1'b0;
      scl_low_q       <= 1'b0;
      own_master_q    <= 1'b0;
      addr_phase_q    <= 1'b0;
      addressed_q     <= 1'b0;
      lost_inflight_q <= 1'b0;
      go_hold_q       <= 1'b0;
      rel_req_q       <= 1'b0;
      tx_q            <= 1'b0;
      slave_q         <= 1'b0;
      start_pulse_q   <= 1'b0;
      stop_pulse_q    <= 1'b0;
    end else begin
      start_pulse_q <= 1'b0;
      stop_pulse_q  <= 1'b0;
      if (!own_master_q && start_det) begin
        // another master (or a repeated start) opens a transfer
        state_q      <= ISI_ST_XFER;
        bit_cnt_q    <= 4'h0;
        addr_phase_q <= 1'b1;
        addressed_q  <= 1'b0;
        tx_q         <= 1'b0;
        slave_q      <= 1'b1;
        sda_low_q    <= 1'b0;
        rel_req_q    <= 1'b0;
      end else if (!own_master_q && stop_det) begin
        state_q     <= ISI_ST_IDLE;
        addressed_q <= 1'b0;
        slave_q     <= 1'b0;
        tx_q        <= 1'b0;
        sda_low_q   <= 1'b0;
        rel_req_q   <= 1'b0;
      end else begin
        case (state_q)
          ISI_ST_IDLE: begin
            phase_q <= 2'h0;
            if (i_start_req && !busy_q) begin
              state_q      <= ISI_ST_START;
              own_master_q <= 1'b1;
              slave_q      <= 1'b0;
            end
          end
          ISI_ST_START: begin
            if (tick) begin
              phase_q <= phase_q + 2'h1;
              if (phase_q == 2'h0) begin
                sda_low_q <= 1'b1;
              end else begin
                scl_low_q     <= 1'b1;
                state_q       <= ISI_ST_XFER;
                phase_q       <= 2'h0;
                bit_cnt_q     <= 4'h0;
                shreg_q       <= data_q;
                tx_q          <= 1'b1;
                addr_phase_q  <= 1'b1;
                start_pulse_q <= 1'b1;
              end
            end
          end
          ISI_ST_XFER: begin
            if (own_master_q && tick
                && !(phase_q == 2'h2 && !scl)) begin
              phase_q <= phase_q + 2'h1;
              if (phase_q == 2'h1) begin
                scl_low_q <= 1'b0;
              end
              if (phase_q == 2'h3) begin
                scl_low_q <= 1'b1;
              end
            end
            if (drive_pt && bit_cnt_q < ISI_ACK_SLOT) begin
              sda_low_q <= tx_q && !shreg_q[7];
            end else if (drive_pt && bit_cnt_q == ISI_ACK_SLOT) begin
              // ack slot: receiver answers, transmitter lets go
              sda_low_q <= !tx_q && i_auto_ack_enable
                         && (slv_addr ? take_addr
                             : (addressed_q || own_master_q));
            end
            if (sample_pt && bit_cnt_q < ISI_ACK_SLOT) begin
              shreg_q   <= {shreg_q[6:0], sda};
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end
            if (ev_lost) begin
              // drop the bus, follow the winner's clock as a slave
              own_master_q    <= 1'b0;
              lost_inflight_q <= 1'b1;
              slave_q         <= 1'b1;
              tx_q            <= 1'b0;
              sda_low_q       <= 1'b0;
              scl_low_q       <= 1'b0;
            end
            if (ack_pt) begin
              bit_cnt_q       <= ISI_ACK_DONE;
              go_hold_q       <= go_hold;
              addr_phase_q    <= 1'b0;
              lost_inflight_q <= 1'b0;
              if (take_addr) begin
                addressed_q <= 1'b1;
                tx_q <= addr_match && shreg_q[0];
              end else if (own_master_q && addr_phase_q) begin
                tx_q <= !shreg_q[0];
              end
            end
            if (bit_cnt_q == ISI_ACK_DONE
                && (!own_master_q || (tick && phase_q == 2'h3))) begin
              rel_req_q <= 1'b0;
              state_q   <= go_hold_q ? ISI_ST_HOLD : ISI_ST_IDLE;
            end
          end
          ISI_ST_HOLD: begin
            if (data_wr || data_rd) begin
              rel_req_q <= 1'b1;
            end
            if (!scl) begin
              sda_low_q <= 1'b0;
              if (own_master_q && i_end_transfer_request) begin
                state_q <= ISI_ST_STOP;
                phase_q <= 2'h0;
              end else if (rel_req_q) begin
                // release only with clock low to avoid a false start
                state_q   <= ISI_ST_XFER;
                rel_req_q <= 1'b0;
                bit_cnt_q <= 4'h0;
                phase_q   <= 2'h0;
                shreg_q   <= data_q;
                sda_low_q <= !own_master_q && tx_q && !data_q[7];
              end
            end
          end
          ISI_ST_STOP: begin
            if (tick) begin
              phase_q <= phase_q + 2'h1;
              if (phase_q == 2'h0) begin
                sda_low_q <= 1'b1;
              end else if (phase_q == 2'h1) begin
                scl_low_q <= 1'b0;
              end else if (scl) begin
                sda_low_q    <= 1'b0;
                own_master_q <= 1'b0;
                tx_q         <= 1'b0;
                stop_pulse_q <= 1'b1;
                state_q      <= ISI_ST_IDLE;
              end
            end
          end
          default: begin
            state_q <= ISI_ST_IDLE;
          end
        endcase
      end
    end
  end

  // ===========================================================
  // status flags
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      gc_q   <= 1'b0;
      stop_q <= 1'b0;
      pend_q <= 1'b0;
      busy_q <= 1'b0;
      lost_q <= 1'b0;
      nack_q <= 1'b0;
    end else begin
      if (ev_gc) begin
        gc_q <= 1'b1;
      end else if (start_det || stop_det) begin
        gc_q <= 1'b0;
      end
      if (stop_det) begin
        stop_q <= 1'b1;
      end else if (start_det) begin
        stop_q <= 1'b0;
      end
      if (start_det) begin
        busy_q <= 1'b1;
      end else if (stop_det) begin
        busy_q <= 1'b0;
      end
      if (ev_lost || (gc_q && !slave_q)) begin
        lost_q <= 1'b1;
      end else if (start_det) begin
        lost_q <= 1'b0;
      end
      if (ack_pt && tx_q) begin
        nack_q <= sda;
      end
      // a new event wins over a clearing write in the same cycle
      if (ev_pend) begin
        pend_q <= 1'b1;
      end else if (stat_wr) begin
        pend_q <= i_sfr_wdata[ISI_PEND_BIT];
      end
    end
  end

  // ===========================================================
  // register port
  always_comb begin
    status = ISI_STATUS_RST;
    status[ISI_GC_BIT]   = gc_q;
    status[ISI_STOP_BIT] = stop_q;
    status[ISI_PEND_BIT] = pend_q;
    status[ISI_TX_BIT]   = tx_q;
    status[ISI_BUSY_BIT] = busy_q;
    status[ISI_LOST_BIT] = lost_q;
    status[ISI_NACK_BIT] = nack_q;
    status[ISI_SLV_BIT]  = slave_q;
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      data_q  <= ISI_DATA_RST;
      own_q   <= ISI_OWN_RST;
      rdata_q <= ISI_UNMAPPED_RD;
    end else begin
      if (rx_capture) begin
        data_q <= {shreg_q[6:0], sda};
      end else if (data_wr) begin
        data_q <= i_sfr_wdata;
      end
      if (i_sfr_wr && i_sfr_addr == ISI_ADDR_OWN) begin
        own_q <= i_sfr_wdata;
      end
      if (i_sfr_rd) begin
        if (i_sfr_addr == ISI_ADDR_STATUS) begin
          rdata_q <= status;
        end else if (i_sfr_addr == ISI_ADDR_DATA) begin
          rdata_q <= data_q;
        end else if (i_sfr_addr == ISI_ADDR_OWN) begin
          rdata_q <= own_q;
        end else begin
          rdata_q <= ISI_UNMAPPED_RD;
        end
      end
    end
  end

  // ===========================================================
  // outputs
  assign o_sfr_rdata  = rdata_q;
  assign o_irq_req    = pend_q && i_engine_en && i_bus_irq_enable
                      && i_global_irq_master;
  assign o_start_done = start_pulse_q;
  assign o_stop_done  = stop_pulse_q;
  assign o_scl_o      = 1'b0;
  assign o_scl_oe     = scl_low_q
                      || (state_q == ISI_ST_HOLD && !scl);
  assign o_sda_o      = 1'b0;
  assign o_sda_oe     = sda_low_q;

endmodule
`default_nettype wire

// ---- tb/isi_bus_master_model.sv ----
// behavioural two-wire master that addresses the block as a slave
`timescale 1ns/1ps
`default_nettype none
module isi_bus_master_model (
  input  wire logic      i_ref_clk,
  input  wire logic      i_scl,
  input  wire logic      i_sda,
  output var logic       o_scl_pull,
  output var logic       o_sda_pull,
  output var logic [7:0] o_stall_cnt
);
  initial begin
    o_scl_pull = 1'b0;
    o_sda_pull = 1'b0;
    o_stall_cnt = 8'h00;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask
  // the slave may stretch the low phase; a stuck line is counted
  task automatic wait_high();
    int t;
    t = 0;
    while (i_scl !== 1'b1 && t < 2000) begin
      @(posedge i_ref_clk);
      t++;
    end
    if (t >= 2000) o_stall_cnt <= o_stall_cnt + 8'h01;
  endtask
  // 80 ns bit: data moves midway through the low phase, sampled mid-high
  task automatic put_bit(input logic b, output logic seen);
    o_sda_pull <= ~b;
    tick(2);
    o_scl_pull <= 1'b0;
    wait_high();
    tick(2);
    seen = i_sda;
    tick(1);
    o_scl_pull <= 1'b1;
    tick(2);
  endtask
  task automatic send_byte(input logic [7:0] b, output logic nack);
    logic s;
    for (int i = 7; i >= 0; i--) put_bit(b[i], s);
    put_bit(1'b1, nack);
  endtask
  task automatic start();
    o_sda_pull <= 1'b1;
    tick(4);
    o_scl_pull <= 1'b1;
    tick(2);
  endtask
  task automatic stop();
    o_sda_pull <= 1'b1;
    tick(2);
    o_scl_pull <= 1'b0;
    wait_high();
    tick(4);
    o_sda_pull <= 1'b0;
    tick(8);
  endtask
endmodule
`default_nettype wire

// ---- tb/isi_status_event_chk.sv ----
// port checker for the two-wire status and event block
`timescale 1ns/1ps
`default_nettype none
module isi_status_event_chk
  import isi_pkg::*;
#(
  parameter int QUARTER_CYC = ISI_QUARTER_CYC
) (
  input wire logic       i_ref_clk,
  input wire logic       i_rst_n,
  input wire logic [7:0] i_sfr_addr,
  input wire logic       i_sfr_wr,
  input wire logic       i_sfr_rd,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic [7:0] o_sfr_rdata,
  input wire logic       i_engine_en,
  input wire logic       i_end_transfer_request,
  input wire logic       i_bus_irq_enable,
  input wire logic       i_global_irq_master,
  input wire logic       o_irq_req,
  input wire logic       o_stop_done,
  input wire logic       o_scl_oe,
  input wire logic       o_sda_oe
);
  // ==================================================
  // helpers
  logic en;
  logic st_wr;
  logic st_rd;
  logic odd_rd;
  assign en = i_engine_en && i_bus_irq_enable && i_global_irq_master;
  assign st_wr = i_sfr_wr && i_sfr_addr == ISI_ADDR_STATUS;
  assign st_rd = i_sfr_rd && i_sfr_addr == ISI_ADDR_STATUS;
  assign odd_rd = i_sfr_rd && !(i_sfr_addr inside
    {ISI_ADDR_STATUS, ISI_ADDR_DATA, ISI_ADDR_OWN});
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  // ==================================================
  // assertions
  irq_gate_a:
    assert property (o_irq_req |-> en) else $error("irq without enables");
  bus_release_a:
    assert property (!i_engine_en [*2] |-> !o_scl_oe && !o_sda_oe)
    else $error("bus pulled while engine off");
  irq_poll_a:
    assert property (st_rd && en |=>
      o_sfr_rdata[ISI_PEND_BIT] == $past(o_irq_req))
    else $error("pending bit differs from irq");
  irq_sticky_a:
    assert property (en && o_irq_req && !st_wr ##1 en |-> o_irq_req)
    else $error("pending cleared by itself");
  pend_write_a:
    assert property (st_wr && i_sfr_wdata[ISI_PEND_BIT] ##1 st_rd |=>
      o_sfr_rdata[ISI_PEND_BIT])
    else $error("pending bit not writable");
  rst_zero_a:
    assert property ($rose(i_rst_n) |-> o_sfr_rdata == ISI_STATUS_RST &&
      !o_irq_req && !o_scl_oe && !o_sda_oe)
    else $error("state after reset not zero");
  odd_read_a:
    assert property (odd_rd |=> o_sfr_rdata == ISI_UNMAPPED_RD)
    else $error("unmapped read not zero");
  stop_cause_a:
    assert property ($rose(o_stop_done) |-> $past(i_end_transfer_request))
    else $error("stop without request");
  irq_seen_c: cover property (o_irq_req);
  ack_seen_c: cover property ($rose(o_sda_oe));
  hold_end_c: cover property ($fell(o_scl_oe));
endmodule
bind isi_status_event isi_status_event_chk #(.QUARTER_CYC(QUARTER_CYC))
  i_chk (.i_ref_clk, .i_rst_n, .i_sfr_addr, .i_sfr_wr, .i_sfr_rd,
  .i_sfr_wdata, .o_sfr_rdata, .i_engine_en, .i_end_transfer_request,
  .i_bus_irq_enable, .i_global_irq_master, .o_irq_req, .o_stop_done,
  .o_scl_oe, .o_sda_oe);
`default_nettype wire

// ---- tb/isi_status_event_test.sv ----
// self-checking bench for the two-wire status and event block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, ac) begin check_count++; if ((ac) !== (ex)) begin \
  err_count++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, ex, ac); end end
module isi_status_event_test;
  import isi_pkg::*;
  logic       clk, rst_n, wr, rd, eng, aa, ben, gen, irq, scl_oe, sda_oe;
  logic       m_scl, m_sda, nk, sta, end_transfer_request, stp;
  logic [7:0] addr, wdata, rdata, rv, own, dat, stall, nbit;
  wire logic  scl_w;
  wire logic  sda_w;
  int         err_count, check_count;
  integer     seed;
  assign scl_w = ~(scl_oe | m_scl);
  assign sda_w = ~(sda_oe | m_sda);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  isi_status_event #(.QUARTER_CYC(4)) i_dut (
    .i_ref_clk(clk), .i_rst_n(rst_n), .i_sfr_addr(addr), .i_sfr_wr(wr),
    .i_sfr_rd(rd), .i_sfr_wdata(wdata), .o_sfr_rdata(rdata),
    .i_engine_en(eng), .i_auto_ack_enable(aa), .i_start_req(sta),
    .i_end_transfer_request(end_transfer_request), .i_bus_irq_enable(ben),
    .i_global_irq_master(gen), .o_irq_req(irq), .o_start_done(),
    .o_stop_done(stp), .i_scl(scl_w), .o_scl_o(), .o_scl_oe(scl_oe),
    .i_sda(sda_w), .o_sda_o(), .o_sda_oe(sda_oe));
  isi_bus_master_model i_master (.i_ref_clk(clk), .i_scl(scl_w),
    .i_sda(sda_w), .o_scl_pull(m_scl), .o_sda_pull(m_sda),
    .o_stall_cnt(stall));
  // ==================================================
  // helpers
  function automatic logic [7:0] exp_st(input logic g, s, p, t, b, v);
    logic [7:0] r;
    r = 8'h00;
    r[ISI_GC_BIT] = g;
    r[ISI_STOP_BIT] = s;
    r[ISI_PEND_BIT] = p;
    r[ISI_TX_BIT] = t;
    r[ISI_BUSY_BIT] = b;
    r[ISI_SLV_BIT] = v;
    return r;
  endfunction
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic sfr_rd(input logic [7:0] a, output logic [7:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic end_test(input string nm);
    $display("test %s done, mismatches %0d", nm, err_count);
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (50000) @(posedge clk);
    err_count++;
    $display("watchdog expired");
    test_done();
  end
  // ==================================================
  // scenarios
  initial begin
    seed = 32'h5385;
    err_count = 0;
    check_count = 0;
    {rst_n, wr, rd, eng, aa, ben, gen, sta, end_transfer_request} = 9'h000;
    nbit = 8'h01 << ISI_NACK_BIT;
    {addr, wdata} = 16'h0000;
    repeat (2) @(posedge clk);
    {rst_n, eng} <= 2'b11;
    @(posedge clk);
    #1;
    sfr_rd(ISI_ADDR_STATUS, rv);
    `CHK("status reset", ISI_STATUS_RST, rv)
    sfr_wr(ISI_ADDR_STATUS, 8'hFF);
    sfr_rd(ISI_ADDR_STATUS, rv);
    `CHK("status write", exp_st(0, 0, 1, 0, 0, 0), rv)
    sfr_wr(ISI_ADDR_STATUS, 8'h00);
    sfr_rd(ISI_ADDR_STATUS, rv);
    `CHK("status clear", ISI_STATUS_RST, rv)
    sfr_rd(8'hA5, rv);
    `CHK("unmapped read", ISI_UNMAPPED_RD, rv)
    eng <= 1'b0;
    repeat (3) @(posedge clk);
    {eng, aa, ben} <= 3'b111;
    end_test("registers");
    own = 8'($random(seed));
    own[7] = 1'b1;
    own[0] = 1'b0;
    sfr_wr(ISI_ADDR_OWN, own);
    i_master.start();
    i_master.send_byte(own, nk);
    `CHK("address ack", 1'b0, nk)
    sfr_rd(ISI_ADDR_STATUS, rv);
    `CHK("addressed", exp_st(0, 0, 1, 0, 1, 1), rv)
    `CHK("irq masked", 1'b0, irq)
    `CHK("clock held", 1'b1, scl_oe)
    gen <= 1'b1;
    @(posedge clk);
    #1;
    `CHK("irq raised", 1'b1, irq)
    sfr_rd(ISI_ADDR_STATUS, rv);
    sfr_wr(ISI_ADDR_STATUS, 8'h00);
    `CHK("irq cleared", 1'b0, irq)
    sfr_rd(ISI_ADDR_DATA, rv);
    `CHK("address byte", own, rv)
    repeat (4) @(posedge clk);
    #1;
    `CHK("clock freed", 1'b0, scl_oe)
    for (int k = 0; k < 4; k++) begin
      dat = (k == 0) ? 8'hFF : 8'($random(seed));
      i_master.send_byte(dat, nk);
      `CHK("data ack", 1'b0, nk)
      sfr_rd(ISI_ADDR_STATUS, rv);
      `CHK("byte status", exp_st(0, 0, 1, 0, 1, 1), rv)
      sfr_wr(ISI_ADDR_STATUS, 8'h00);
      sfr_rd(ISI_ADDR_DATA, rv);
      `CHK("data byte", dat, rv)
    end
    i_master.stop();
    sfr_rd(ISI_ADDR_STATUS, rv);
    `CHK("stop status", exp_st(0, 1, 1, 0, 0, 0), rv)
    sfr_wr(ISI_ADDR_STATUS, 8'h00);
    end_test("addressed write");
    for (int k = 0; k < 2; k++) begin
      aa <= k[0] ? 1'b0 : 1'b1;
      i_master.start();
      i_master.send_byte(k[0] ? own : own ^ 8'h02, nk);
      `CHK("refused ack", 1'b1, nk)
      sfr_rd(ISI_ADDR_STATUS, rv);
      `CHK("refused", exp_st(0, 0, 0, 0, 1, 1), rv)
      i_master.stop();
      sfr_rd(ISI_ADDR_STATUS, rv);
      if (k == 0) `CHK("foreign stop", exp_st(0, 1, 0, 0, 0, 0), rv)
    end
    end_test("refused address");
    aa <= 1'b1;
    i_master.start();
    i_master.send_byte({ISI_GC_ADDR, 1'b0}, nk);
    `CHK("call ack", 1'b0, nk)
    sfr_rd(ISI_ADDR_STATUS, rv);
    `CHK("call status", exp_st(1, 0, 1, 0, 1, 1), rv)
    sfr_wr(ISI_ADDR_STATUS, 8'h00);
    sfr_rd(ISI_ADDR_DATA, rv);
    i_master.stop();
    sfr_rd(ISI_ADDR_STATUS, rv);
    `CHK("call cleared", 1'b0, rv[ISI_GC_BIT])
    `CHK("bus stalls", 8'h00, stall)
    end_test("general call");
    // own transfer with nobody answering: nack, hold, stop on request
    sfr_wr(ISI_ADDR_STATUS, 8'h00);
    sfr_wr(ISI_ADDR_DATA, own);
    sta <= 1'b1;
    for (int t = 0; t < 2000 && !irq; t++) begin
      @(posedge clk);
      #1;
    end
    sta <= 1'b0;
    `CHK("master irq", 1'b1, irq)
    sfr_rd(ISI_ADDR_STATUS, rv);
    `CHK("master byte", exp_st(0, 0, 1, 1, 1, 0) | nbit, rv)
    repeat (12) @(posedge clk);
    #1;
    `CHK("master hold", 1'b1, scl_oe)
    end_transfer_request <= 1'b1;
    for (int t = 0; t < 200 && !stp; t++) begin
      @(posedge clk);
      #1;
    end
    `CHK("master stop", 1'b1, stp)
    end_transfer_request <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    sfr_rd(ISI_ADDR_STATUS, rv);
    `CHK("master end", exp_st(0, 1, 1, 0, 0, 0) | nbit, rv)
    end_test("master nack");
    test_done();
  end
endmodule
`default_nettype wire
